// ===== src/gpio_pkg.sv
// Package: register map, field positions and bus carrier for the port block
package gpio_pkg;

  // Register offsets in the data-memory window
  localparam logic [7:0] L_DATA_OFS   = 8'hD0;
  localparam logic [7:0] L_CFG_OFS    = 8'hD1;
  localparam logic [7:0] L_PIN_OFS    = 8'hD2;
  localparam logic [7:0] G_DATA_OFS   = 8'hD4;
  localparam logic [7:0] G_CFG_OFS    = 8'hD5;
  localparam logic [7:0] G_PIN_OFS    = 8'hD6;
  localparam logic [7:0] D_DATA_OFS   = 8'hDC;
  localparam logic [7:0] SER_CTRL_OFS = 8'hEE;
  localparam logic [7:0] CAN_CTRL_OFS = 8'hE0;
  localparam logic [7:0] ALT_SEL_OFS  = 8'hE8;

  // Field positions
  localparam int G_HALT_BIT     = 7;
  localparam int G_IDLE_BIT     = 6;
  localparam int G_ALT_SK_BIT   = 6;
  localparam int SER_SEL_BIT    = 3;
  localparam int CAN_TXEN_A_BIT = 0;
  localparam int CAN_TXEN_B_BIT = 1;
  localparam int ALT_CMP2_BIT   = 0;
  localparam int ALT_PWMA_BIT   = 1;
  localparam int ALT_PWMB_BIT   = 2;
  localparam int ALT_CMP1_BIT   = 3;

  // Reset values and the G data read mask
  localparam logic [7:0] PORT_RST   = 8'h00;
  localparam logic [3:0] D_RST      = 4'hF;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] G_RD_MASK  = 8'h3F;

  // CPU data-memory access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mem_req_t;

endpackage

// ===== src/port_g_l_d_io_block.sv
// Port L, G and D pin logic with CAN transmit drivers and register file
// How it works
// - Config/data pair picks hi-Z, pull-up, low, high
// - Config, data and pin-read locations for L and G; D has data only
// - Seven L bits, each a wake-up source
// - G0-G5 I/O, G6 input, G7 clock out
// - G data reads zero in bits 6, 7
// - Writing G data bit 7 requests halt
// - Writing G data bit 6 requests idle
// - G config bit 6 selects alternate shift phase
// - CAN output A driven only when enabled
// - CAN output B driven only when enabled
// - D port four outputs, high during reset
// - L alternate comparator, PWM, capture, wake-up
// - G alternate serial, timer, interrupt functions
// - Serial select moves G5, G4 to serial
// - Reset clears L, G registers to hi-Z
module port_g_l_d_io_block
  import gpio_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire mem_req_t   mem_req,
  output logic     [7:0]  rd_data,
  input  wire logic [6:0] l_pin_in,
  output logic     [6:0]  l_pin_out,
  output logic     [6:0]  l_pin_oe,
  output logic     [6:0]  l_pin_pullup,
  input  wire logic [6:0] g_pin_in,
  output logic     [5:0]  g_pin_out,
  output logic     [5:0]  g_pin_oe,
  output logic     [5:0]  g_pin_pullup,
  input  wire logic       osc_clk_in,
  output logic            oscillator_clock_out,
  output logic     [3:0]  d_pin_out,
  output logic            halt_request,
  output logic            idle_request,
  output logic            serial_alt_phase,
  output logic            serial_pin_select,
  input  wire logic       serial_shift_clock,
  input  wire logic       serial_data_out,
  output logic            serial_data_in,
  output logic     [6:0]  multi_input_wakeup,
  input  wire logic       comparator_one_output,
  input  wire logic       comparator_two_output,
  input  wire logic       pulse_width_out_a,
  input  wire logic       pulse_width_out_b,
  output logic            capture_input_pin,
  output logic            timer_one_io,
  output logic            timer_one_capture_in,
  output logic            external_interrupt_in,
  input  wire logic       can_tx_a,
  input  wire logic       can_tx_b,
  output logic            can_transmit_out_a,
  output logic            can_transmit_out_b,
  output logic            can_transmit_oe_a,
  output logic            can_transmit_oe_b,
  output logic            can_tx_drive_enable_a,
  output logic            can_tx_drive_enable_b,
  input  wire logic       can_receive_in_a,
  input  wire logic       can_receive_in_b,
  output logic            can_rx_a,
  output logic            can_rx_b
);

  logic [7:0] l_data_q;
  logic [7:0] l_cfg_q;
  logic [7:0] g_data_q;
  logic [7:0] g_cfg_q;
  logic [3:0] d_data_q;
  logic [7:0] ser_ctrl_q;
  logic [7:0] can_ctrl_q;
  logic [7:0] alt_sel_q;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic       halt_q;
  logic       idle_q;
  logic [6:0] l_meta_q;
  logic [6:0] l_sync_q;
  logic [6:0] g_meta_q;
  logic [6:0] g_sync_q;
  logic [1:0] rx_meta_q;
  logic [1:0] rx_sync_q;

  // Address decode
  wire wr_l_data = mem_req.wr && mem_req.addr == L_DATA_OFS;
  wire wr_l_cfg  = mem_req.wr && mem_req.addr == L_CFG_OFS;
  wire wr_g_data = mem_req.wr && mem_req.addr == G_DATA_OFS;
  wire wr_g_cfg  = mem_req.wr && mem_req.addr == G_CFG_OFS;
  wire wr_d_data = mem_req.wr && mem_req.addr == D_DATA_OFS;
  wire wr_ser    = mem_req.wr && mem_req.addr == SER_CTRL_OFS;
  wire wr_can    = mem_req.wr && mem_req.addr == CAN_CTRL_OFS;
  wire wr_alt    = mem_req.wr && mem_req.addr == ALT_SEL_OFS;

  // Read mux; pins come from synchronizers, not the registers
  always_comb begin
    rd_data_d = 8'h00;
    case (mem_req.addr)
      L_DATA_OFS:   rd_data_d = {1'b0, l_data_q[6:0]};
      L_CFG_OFS:    rd_data_d = {1'b0, l_cfg_q[6:0]};
      L_PIN_OFS:    rd_data_d = {1'b0, l_sync_q};
      G_DATA_OFS:   rd_data_d = g_data_q & G_RD_MASK;
      G_CFG_OFS:    rd_data_d = g_cfg_q;
      G_PIN_OFS:    rd_data_d = {1'b0, g_sync_q};
      D_DATA_OFS:   rd_data_d = {4'h0, d_data_q};
      SER_CTRL_OFS: rd_data_d = ser_ctrl_q;
      CAN_CTRL_OFS: rd_data_d = can_ctrl_q;
      ALT_SEL_OFS:  rd_data_d = alt_sel_q;
      default:      rd_data_d = 8'h00;
    endcase
  end

  // Port registers; reset leaves L and G as hi-Z inputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      l_data_q <= PORT_RST;
      l_cfg_q  <= PORT_RST;
      g_data_q <= PORT_RST;
      g_cfg_q  <= PORT_RST;
      d_data_q <= D_RST;
    end else begin
      if (wr_l_data) l_data_q <= {1'b0, mem_req.wdata[6:0]};
      if (wr_l_cfg)  l_cfg_q  <= {1'b0, mem_req.wdata[6:0]};
      if (wr_g_data) g_data_q <= mem_req.wdata & G_RD_MASK;
      if (wr_g_cfg)  g_cfg_q  <= mem_req.wdata;
      if (wr_d_data) d_data_q <= mem_req.wdata[3:0];
    end
  end

  // Control registers and read data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ser_ctrl_q <= CTRL_RST;
      can_ctrl_q <= CTRL_RST;
      alt_sel_q  <= CTRL_RST;
      rd_data_q  <= 8'h00;
    end else begin
      if (wr_ser) ser_ctrl_q <= mem_req.wdata;
      if (wr_can) can_ctrl_q <= mem_req.wdata;
      if (wr_alt) alt_sel_q  <= mem_req.wdata;
      if (mem_req.rd) rd_data_q <= rd_data_d;
    end
  end

  // Low-power requests, one cycle after the write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      halt_q <= 1'b0;
      idle_q <= 1'b0;
    end else begin
      halt_q <= wr_g_data && mem_req.wdata[G_HALT_BIT];
      idle_q <= wr_g_data && mem_req.wdata[G_IDLE_BIT];
    end
  end

  // Two-flop synchronizers for every pin input
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      l_meta_q  <= 7'h00;
      l_sync_q  <= 7'h00;
      g_meta_q  <= 7'h00;
      g_sync_q  <= 7'h00;
      rx_meta_q <= 2'h3;
      rx_sync_q <= 2'h3;
    end else begin
      l_meta_q  <= l_pin_in;
      l_sync_q  <= l_meta_q;
      g_meta_q  <= g_pin_in;
      g_sync_q  <= g_meta_q;
      rx_meta_q <= {can_receive_in_b, can_receive_in_a};
      rx_sync_q <= rx_meta_q;
    end
  end

  // Selects for alternate outputs
  wire ser_sel  = ser_ctrl_q[SER_SEL_BIT];
  wire alt_cmp2 = alt_sel_q[ALT_CMP2_BIT];
  wire alt_pwma = alt_sel_q[ALT_PWMA_BIT];
  wire alt_pwmb = alt_sel_q[ALT_PWMB_BIT];
  wire alt_cmp1 = alt_sel_q[ALT_CMP1_BIT];

  // L port drivers per bit, alternates override the data bit
  genvar i;
  generate
    for (i = 0; i < 7; i++) begin : g_l_bit
      logic alt_on;
      logic alt_val;
      if (i == 6) begin : g_l6
        assign alt_on  = alt_cmp2 | alt_pwma;
        assign alt_val = alt_cmp2 ? comparator_two_output
                                  : pulse_width_out_a;
      end else if (i == 5) begin : g_l5
        assign alt_on  = alt_pwmb;
        assign alt_val = pulse_width_out_b;
      end else if (i == 2) begin : g_l2
        assign alt_on  = alt_cmp1;
        assign alt_val = comparator_one_output;
      end else begin : g_lx
        assign alt_on  = 1'b0;
        assign alt_val = 1'b0;
      end
      assign l_pin_oe[i]     = alt_on | l_cfg_q[i];
      assign l_pin_out[i]    = alt_on ? alt_val : l_data_q[i];
      assign l_pin_pullup[i] = !alt_on && !l_cfg_q[i] && l_data_q[i];
    end
  endgenerate

  // G port drivers; G5, G4 follow the serial engine when selected
  always_comb begin
    g_pin_oe     = g_cfg_q[5:0];
    g_pin_out    = g_data_q[5:0];
    g_pin_pullup = ~g_cfg_q[5:0] & g_data_q[5:0];
    if (ser_sel) begin
      g_pin_oe[5]     = 1'b1;
      g_pin_out[5]    = serial_shift_clock;
      g_pin_pullup[5] = 1'b0;
      g_pin_oe[4]     = 1'b1;
      g_pin_out[4]    = serial_data_out;
      g_pin_pullup[4] = 1'b0;
    end
  end

  // Wake-up and alternate inputs from synchronized pins
  assign multi_input_wakeup    = l_sync_q;
  assign capture_input_pin     = l_sync_q[6];
  assign serial_data_in        = g_sync_q[6];
  assign timer_one_io          = g_sync_q[3];
  assign timer_one_capture_in  = g_sync_q[2];
  assign external_interrupt_in = g_sync_q[0];
  assign oscillator_clock_out  = osc_clk_in;
  assign serial_alt_phase      = g_cfg_q[G_ALT_SK_BIT];
  assign serial_pin_select     = ser_sel;

  // CAN transmit drivers gated by their enables
  assign can_tx_drive_enable_a = can_ctrl_q[CAN_TXEN_A_BIT];
  assign can_tx_drive_enable_b = can_ctrl_q[CAN_TXEN_B_BIT];
  assign can_transmit_oe_a     = can_tx_drive_enable_a;
  assign can_transmit_oe_b     = can_tx_drive_enable_b;
  assign can_transmit_out_a    = can_tx_a;
  assign can_transmit_out_b    = can_tx_b;
  assign can_rx_a              = rx_sync_q[0];
  assign can_rx_b              = rx_sync_q[1];

  // D port forced high while reset is held
  assign d_pin_out    = d_data_q | {4{~rst_n}};
  assign halt_request = halt_q;
  assign idle_request = idle_q;
  assign rd_data      = rd_data_q;

endmodule

// ===== tb/port_io_props.sv
// Checker: timing relations on the port block outputs
module port_io_props
  import gpio_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire mem_req_t   mem_req,
  input wire logic [7:0] rd_data,
  input wire logic [6:0] l_pin_oe,
  input wire logic [6:0] l_pin_pullup,
  input wire logic [5:0] g_pin_oe,
  input wire logic [3:0] d_pin_out,
  input wire logic       halt_request,
  input wire logic       idle_request,
  input wire logic       serial_alt_phase,
  input wire logic       can_transmit_oe_a,
  input wire logic       can_transmit_oe_b
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Decoded register writes and G data read
  wire wr_gd = mem_req.wr && mem_req.addr == G_DATA_OFS && rst_n;
  wire wr_gc = mem_req.wr && mem_req.addr == G_CFG_OFS;
  wire wr_cn = mem_req.wr && mem_req.addr == CAN_CTRL_OFS;
  wire rd_gd = mem_req.rd && mem_req.addr == G_DATA_OFS;
  a_halt_pulse: assert property (
    halt_request == $past(wr_gd && mem_req.wdata[7]))
    else $error("halt pulse wrong");
  a_idle_pulse: assert property (
    idle_request == $past(wr_gd && mem_req.wdata[6]))
    else $error("idle pulse wrong");
  a_alt_phase_set: assert property (
    wr_gc |=> serial_alt_phase == $past(mem_req.wdata[6]))
    else $error("phase bit wrong");
  a_can_enable_a: assert property (
    wr_cn |=> can_transmit_oe_a == $past(mem_req.wdata[0]))
    else $error("can a enable wrong");
  a_can_enable_b: assert property (
    wr_cn |=> can_transmit_oe_b == $past(mem_req.wdata[1]))
    else $error("can b enable wrong");
  a_g_read_mask: assert property (
    rd_gd |=> rd_data[7:6] == 2'b00)
    else $error("g data top bits set");
  a_no_pull_drive: assert property (
    (l_pin_pullup & l_pin_oe) == 7'h00)
    else $error("pull-up while driving");
  a_d_reset_high: assert property (
    disable iff (1'b0) !rst_n |-> d_pin_out == 4'hF)
    else $error("d port not high");
  a_reset_hiz_pins: assert property (
    disable iff (1'b0) !rst_n |=> l_pin_oe == 7'h00 && g_pin_oe == 6'h00
      && l_pin_pullup == 7'h00)
    else $error("pins not hi-z");
endmodule
bind port_g_l_d_io_block port_io_props u_props (.clk, .rst_n, .mem_req,
  .rd_data, .l_pin_oe, .l_pin_pullup, .g_pin_oe, .d_pin_out, .halt_request,
  .idle_request, .serial_alt_phase, .can_transmit_oe_a, .can_transmit_oe_b);

// ===== tb/port_g_l_d_io_block_tb.sv
// Testbench: register accesses and pin checks for the port block
module port_g_l_d_io_block_tb
  import gpio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, osc_clk_in, serial_shift_clock, serial_data_out;
  logic comparator_one_output, comparator_two_output, pulse_width_out_a;
  logic pulse_width_out_b, can_tx_a, can_tx_b, can_receive_in_a;
  logic can_receive_in_b, oscillator_clock_out, halt_request, idle_request;
  logic serial_alt_phase, serial_pin_select, serial_data_in, timer_one_io;
  logic capture_input_pin, timer_one_capture_in, external_interrupt_in;
  logic can_transmit_out_a, can_transmit_out_b, can_transmit_oe_a;
  logic can_transmit_oe_b, can_tx_drive_enable_a, can_tx_drive_enable_b;
  logic can_rx_a, can_rx_b;
  mem_req_t   mem_req;
  logic [7:0] rd_data;
  logic [6:0] l_pin_in, l_pin_out, l_pin_oe, l_pin_pullup, g_pin_in;
  logic [6:0] multi_input_wakeup;
  logic [5:0] g_pin_out, g_pin_oe, g_pin_pullup;
  logic [3:0] d_pin_out;
  int         err_total = 0;
  int         checks = 0;
  int         cyc = 0;
  port_g_l_d_io_block DUT (.*);
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string what);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus cycle, strobe raised and dropped after edges
  task automatic acc(input logic [7:0] a, input logic [7:0] d,
                     input logic w);
    @(posedge clk) #10 mem_req = '{a, d, w, !w};
    @(posedge clk) #10 mem_req = '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(a, d, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string what);
    acc(a, 8'h00, 1'b0);
    chk(rd_data, exp, what);
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    mem_req = '0;
    l_pin_in = 7'h55;
    g_pin_in = 7'h4D;
    {osc_clk_in, serial_shift_clock, serial_data_out} = 3'b010;
    {comparator_one_output, comparator_two_output} = 2'b11;
    {pulse_width_out_a, pulse_width_out_b, can_tx_a, can_tx_b} = 4'h6;
    {can_receive_in_a, can_receive_in_b} = 2'b01;
    repeat (20) @(posedge clk);
    #10 chk(8'(d_pin_out), 8'h0F, "d reset");
    chk(8'(l_pin_oe), 8'h00, "l oe reset");
    rst_n = 1'b1;
    rd(L_CFG_OFS, 8'h00, "l cfg");
    rd(G_DATA_OFS, 8'h00, "g data");
    for (int m = 0; m < 4; m++) begin
      wr(L_CFG_OFS, m[1] ? 8'h7F : 8'h00);
      wr(L_DATA_OFS, m[0] ? 8'h7F : 8'h00);
      wr(G_CFG_OFS, m[1] ? 8'h3F : 8'h00);
      wr(G_DATA_OFS, m[0] ? 8'h3F : 8'h00);
      chk(8'(l_pin_oe), m[1] ? 8'h7F : 8'h00, "l oe");
      chk(8'(l_pin_pullup), m == 1 ? 8'h7F : 8'h00, "l pull");
      chk(8'(l_pin_out & l_pin_oe), m > 2 ? 8'h7F : 8'h00, "l out");
      chk(8'(g_pin_oe), m[1] ? 8'h3F : 8'h00, "g oe");
      chk(8'(g_pin_pullup), m == 1 ? 8'h3F : 8'h00, "g pull");
    end
    rd(L_PIN_OFS, 8'h55, "l pins");
    rd(G_PIN_OFS, 8'h4D, "g pins");
    rd(L_DATA_OFS, 8'h7F, "l data");
    chk(8'(multi_input_wakeup), 8'h55, "wake in");
    chk(8'(capture_input_pin), 8'h01, "capture in");
    chk({4'h0, serial_data_in, timer_one_io, timer_one_capture_in,
         external_interrupt_in}, 8'h0F, "g alt in");
    chk({6'h0, can_rx_b, can_rx_a}, 8'h02, "can rx");
    // New pin level shows only after two synchronizer edges
    l_pin_in = 7'h2A;
    rd(L_PIN_OFS, 8'h55, "l pin lag");
    rd(L_PIN_OFS, 8'h2A, "l pin new");
    // Clock output follows its source
    chk(8'(oscillator_clock_out), 8'h00, "clk out low");
    osc_clk_in = 1'b1;
    #1 chk(8'(oscillator_clock_out), 8'h01, "clk out high");
    wr(G_DATA_OFS, 8'hFF);
    chk(8'(halt_request), 8'h01, "halt");
    chk(8'(idle_request), 8'h01, "idle");
    rd(G_DATA_OFS, 8'h3F, "g data mask");
    wr(G_DATA_OFS, 8'h40);
    chk({6'h0, halt_request, idle_request}, 8'h01, "idle only");
    wr(G_CFG_OFS, 8'h40);
    chk({7'h0, serial_alt_phase}, 8'h01, "alt phase");
    wr(SER_CTRL_OFS, 8'h08);
    chk({serial_pin_select, g_pin_oe[5:4], g_pin_out[5:4], 3'h0}, 8'hF0,
        "serial sel");
    wr(L_CFG_OFS, 8'h00);
    wr(ALT_SEL_OFS, 8'h01);
    chk({l_pin_oe[6], l_pin_out[6], 6'h0}, 8'hC0, "l6 alt");
    for (int e = 1; e < 3; e++) begin
      wr(CAN_CTRL_OFS, 8'(e));
      chk(8'(can_transmit_oe_a), 8'(e[0]), "can oe a");
      chk(8'(can_transmit_oe_b), 8'(e[1]), "can oe b");
      chk(8'(can_tx_drive_enable_a), 8'(e[0]), "can en a");
      chk(8'(can_tx_drive_enable_b), 8'(e[1]), "can en b");
    end
    chk(8'(can_transmit_out_a), 8'h01, "can out a");
    chk(8'(can_transmit_out_b), 8'h00, "can out b");
    wr(D_DATA_OFS, 8'h05);
    chk(8'(d_pin_out), 8'h05, "d data");
    rd(8'h80, 8'h00, "unmapped");
    rst_n = 1'b0;
    #1 chk(8'(d_pin_out), 8'h0F, "d mid reset");
    @(posedge clk) #10 chk(8'(g_pin_oe), 8'h00, "g oe reset");
    end_of_test();
  end
endmodule
